/* File: core/fmc_pkg.sv */
package fmc_pkg;
  // Clock
  localparam int CLK_PERIOD_NS = 10;
  // Pin timing in ns (least times, rounded up to cycles)
  localparam int RESET_PULSE_MIN_NS = 25000;
  localparam int WAKE_TO_READ_NS = 150;
  localparam int WAKE_TO_WRITE_NS = 1000;
  localparam int READ_ACCESS_NS = 150;
  localparam int WRITE_PULSE_NS = 70;
  localparam int RESET_PULSE_CYC = (RESET_PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WAKE_READ_CYC = (WAKE_TO_READ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WAKE_WRITE_CYC = (WAKE_TO_WRITE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WAKE_MAX_CYC = (WAKE_READ_CYC > WAKE_WRITE_CYC) ? WAKE_READ_CYC : WAKE_WRITE_CYC;
  localparam int READ_ACCESS_CYC = (READ_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WRITE_PULSE_CYC = (WRITE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Synchroniser depth on pin inputs; read sampling waits this much longer
  localparam int SYNC_STAGES = 2;
  localparam int CNT_W = 12;
  // Register byte offsets
  localparam logic [11:0] OFS_CTRL = 12'h000;
  localparam logic [11:0] OFS_ADDR = 12'h004;
  localparam logic [11:0] OFS_WDATA = 12'h008;
  localparam logic [11:0] OFS_CMD = 12'h00C;
  localparam logic [11:0] OFS_WDATA2 = 12'h010;
  localparam logic [11:0] OFS_RDATA = 12'h014;
  localparam logic [11:0] OFS_STATUS = 12'h018;
  // CTRL fields
  localparam int CTRL_PROG_EN = 0;
  localparam int CTRL_SLEEP = 1;
  localparam logic [1:0] CTRL_RESET = 2'h0;
  // CMD fields
  localparam int CMD_START = 0;
  localparam int CMD_WRITE = 1;
  localparam int CMD_MODE_ARRAY = 2;
  localparam int CMD_PAIR = 3;
  // STATUS fields
  localparam int ST_CYC_BUSY = 0;
  localparam int ST_WRITE_OK = 1;
  localparam int ST_READ_OK = 2;
  localparam int ST_ENGINE_READY = 3;
  localparam int ST_ARRAY_MODE = 4;
  localparam int ST_REFUSED = 5;
  localparam int ST_SLEEPING = 6;
  // Bus cycle sequencer states
  typedef enum logic [2:0] {
    CY_IDLE = 3'b000,
    CY_SETUP = 3'b001,
    CY_STROBE = 3'b010,
    CY_HOLD = 3'b011,
    CY_GAP = 3'b100
  } fmc_cyc_e;
endpackage : fmc_pkg

/* File: core/fmc_req_if.sv */
`timescale 1ns/1ps
// Request and answer between register front end and pin sequencer
interface fmc_req_if #(parameter int ADDR_W = 24, parameter int DATA_W = 16);
  logic valid; // Request pending
  logic ready; // Sequencer idle, takes request
  logic is_write; // Write cycle when high
  logic pair; // Issue a second write right after the first
  logic [ADDR_W-1:0] addr; // Flash word address
  logic [DATA_W-1:0] wdata; // First write data
  logic [DATA_W-1:0] wdata2; // Second write data
  logic done; // One-cycle pulse when the whole request ends
  logic [DATA_W-1:0] rdata; // Read data, valid from done on
  modport ctl (output valid, is_write, pair, addr, wdata, wdata2, input ready, done, rdata);
  modport eng (input valid, is_write, pair, addr, wdata, wdata2, output ready, done, rdata);
endinterface : fmc_req_if

/* File: core/fmc_cycle.sv */
`timescale 1ns/1ps
// Drives one read, one write or a write pair on the flash pins
module fmc_cycle
  import fmc_pkg::*;
#(
  parameter int ADDR_W = 24,
  parameter int DATA_W = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  fmc_req_if.eng req,
  output logic select_a,
  output logic select_b,
  output logic select_c,
  output logic output_drive_n,
  output logic write_strobe_n,
  output logic [ADDR_W-1:0] flash_addr,
  output logic [DATA_W-1:0] data_lines_out,
  output logic data_lines_oe,
  input wire logic [DATA_W-1:0] data_lines_in
);
  fmc_cyc_e state; // Current phase
  fmc_cyc_e next_state; // Phase for the next cycle
  logic [CNT_W-1:0] cnt; // Strobe length counter
  logic lat_write; // Latched direction
  logic lat_pair; // Latched pair request
  logic second; // Second write of a pair in progress
  logic [DATA_W-1:0] lat_wdata2; // Held until the second write
  logic [DATA_W-1:0] data_meta; // First sync stage, read only by data_sync
  logic [DATA_W-1:0] data_sync; // Synchronised data lines
  logic wr; // Direction seen by this cycle's decisions
  logic strobe_end; // Last strobe cycle

  // Only take work when idle
  assign req.ready = (state == CY_IDLE);
  assign wr = (state == CY_IDLE) ? req.is_write : lat_write;
  assign strobe_end = (state == CY_STROBE) && (cnt == CNT_W'(1));

  // Phase sequencing
  always_comb begin
    next_state = state;
    case (state)
      CY_IDLE: begin
        if (req.valid) begin
          next_state = CY_SETUP;
        end
      end
      CY_SETUP: next_state = CY_STROBE;
      CY_STROBE: begin
        if (strobe_end) begin
          next_state = CY_HOLD;
        end
      end
      CY_HOLD: next_state = CY_GAP;
      CY_GAP: begin
        // Both halves of a command pair go out back to back
        if (lat_pair && !second) begin
          next_state = CY_SETUP;
        end else begin
          next_state = CY_IDLE;
        end
      end
      default: next_state = CY_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= CY_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Strobe counter: reads wait the access time plus the synchroniser
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= '0;
    end else if (state == CY_SETUP) begin
      cnt <= lat_write ? CNT_W'(WRITE_PULSE_CYC) : CNT_W'(READ_ACCESS_CYC + SYNC_STAGES);
    end else if (state == CY_STROBE) begin
      cnt <= cnt - CNT_W'(1);
    end
  end

  // Request latches and pair tracking
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lat_write <= 1'b0;
      lat_pair <= 1'b0;
      second <= 1'b0;
      lat_wdata2 <= '0;
    end else if (state == CY_IDLE && req.valid) begin
      lat_write <= req.is_write;
      lat_pair <= req.pair && req.is_write;
      second <= 1'b0;
      lat_wdata2 <= req.wdata2;
    end else if (state == CY_GAP && next_state == CY_SETUP) begin
      second <= 1'b1;
    end
  end

  // Pin drive, registered from the next phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      select_a <= 1'b1;
      select_b <= 1'b1;
      select_c <= 1'b1;
      output_drive_n <= 1'b1;
      write_strobe_n <= 1'b1;
      data_lines_oe <= 1'b0;
    end else begin
      // All-low enables; all-high idles, a combination never relied on elsewhere
      select_a <= !(next_state inside {CY_SETUP, CY_STROBE, CY_HOLD});
      select_b <= !(next_state inside {CY_SETUP, CY_STROBE, CY_HOLD});
      select_c <= !(next_state inside {CY_SETUP, CY_STROBE, CY_HOLD});
      // Output drive and strobe are never low together
      output_drive_n <= !(next_state == CY_STROBE && !wr);
      write_strobe_n <= !(next_state == CY_STROBE && wr);
      // Data held through HOLD so the strobe rise catches it
      data_lines_oe <= wr && (next_state inside {CY_SETUP, CY_STROBE, CY_HOLD});
    end
  end

  // Address and write data loaded when a request is taken; only write data reloads for the second setup of a pair
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flash_addr <= '0;
      data_lines_out <= '0;
    end else if (state == CY_IDLE && req.valid) begin
      flash_addr <= req.addr;
      data_lines_out <= req.wdata;
    end else if (state == CY_GAP && next_state == CY_SETUP) begin
      data_lines_out <= lat_wdata2;
    end
  end

  // Two-stage synchroniser on the data pins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      data_meta <= '0;
      data_sync <= '0;
    end else begin
      data_meta <= data_lines_in;
      data_sync <= data_meta;
    end
  end

  // Sample read data at the end of the output-drive pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      req.rdata <= '0;
    end else if (strobe_end && !lat_write) begin
      req.rdata <= data_sync;
    end
  end

  // End-of-request pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      req.done <= 1'b0;
    end else begin
      req.done <= (state == CY_GAP) && (next_state == CY_IDLE);
    end
  end
endmodule : fmc_cycle

/* File: core/fmc_top.sv */
// Implementation choices: the placing of the registers and register access over APB.
`timescale 1ns/1ps
// Flash bus controller: APB registers in front, flash pins behind
module fmc_top
  import fmc_pkg::*;
#(
  parameter int ADDR_W = 24,
  parameter int DATA_W = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic select_a,
  output logic select_b,
  output logic select_c,
  output logic output_drive_n,
  output logic write_strobe_n,
  output logic reset_sleep_n,
  output logic program_enable_level,
  output logic [ADDR_W-1:0] flash_addr,
  output logic [DATA_W-1:0] data_lines_out,
  output logic data_lines_oe,
  input wire logic [DATA_W-1:0] data_lines_in,
  input wire logic completion_indicator
);
  // Refuse widths the registers cannot hold
  if (ADDR_W < 1 || ADDR_W > 32 || DATA_W < 8 || DATA_W > 16) begin : g_chk
    $error("fmc_top: ADDR_W must be 1..32 and DATA_W 8..16");
  end

  fmc_req_if #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) req ();

  logic [1:0] ctrl; // Program enable and sleep request
  logic [ADDR_W-1:0] addr_reg; // Target address
  logic [DATA_W-1:0] wdata_reg; // First write data
  logic [DATA_W-1:0] wdata2_reg; // Second write data of a pair
  logic cmd_pend; // Request waiting for the sequencer
  logic cmd_write; // Direction of pending request
  logic cmd_pair; // Pair flag of pending request
  logic cmd_mode_array; // Request is the read-array selection
  logic refused; // Sticky: a request was turned away
  logic array_mode; // Device believed to be in read-array mode
  logic [CNT_W-1:0] rst_cnt; // Cycles spent with reset_sleep_n low
  logic [CNT_W-1:0] wake_cnt; // Cycles since reset_sleep_n rose
  logic ci_meta; // First sync stage, read only by ci_sync
  logic ci_sync; // Synchronised completion indicator
  logic cyc_busy; // A bus cycle pending or running
  logic read_ok; // Wake-to-read time elapsed
  logic write_ok; // Wake-to-write time elapsed
  logic wr_acc; // APB write access phase
  logic cmd_hit; // Start command written this access
  logic cmd_bad; // Start command must be refused
  logic addr_ok; // Mapped address
  logic [31:0] status; // Status word

  assign pready = 1'b1; // Zero-wait slave
  assign wr_acc = psel && penable && pwrite;
  assign addr_ok = paddr inside {OFS_CTRL, OFS_ADDR, OFS_WDATA, OFS_CMD, OFS_WDATA2,
                                 OFS_RDATA, OFS_STATUS};
  assign pslverr = psel && penable && !addr_ok;
  assign cyc_busy = cmd_pend || !req.ready;
  assign program_enable_level = ctrl[CTRL_PROG_EN]; // Software raises it to alter
  // Wake delays kept before any access
  assign read_ok = reset_sleep_n && (wake_cnt >= CNT_W'(WAKE_READ_CYC));
  assign write_ok = reset_sleep_n && (wake_cnt >= CNT_W'(WAKE_WRITE_CYC));
  assign cmd_hit = wr_acc && (paddr == OFS_CMD) && pwdata[CMD_START];
  // No commands while asleep, waking or with sleep requested, so a command can never
  // slip in on the edge at which reset_sleep_n falls
  assign cmd_bad = cyc_busy || ctrl[CTRL_SLEEP] ||
                   (pwdata[CMD_WRITE] ? !write_ok : !read_ok);

  // Software registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= CTRL_RESET;
      addr_reg <= '0;
      wdata_reg <= '0;
      wdata2_reg <= '0;
    end else if (wr_acc) begin
      case (paddr)
        OFS_CTRL: ctrl <= pwdata[1:0];
        OFS_ADDR: addr_reg <= pwdata[ADDR_W-1:0];
        OFS_WDATA: wdata_reg <= pwdata[DATA_W-1:0];
        OFS_WDATA2: wdata2_reg <= pwdata[DATA_W-1:0];
        default: ;
      endcase
    end
  end

  // Command capture; handed over when the sequencer is idle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_pend <= 1'b0;
      cmd_write <= 1'b0;
      cmd_pair <= 1'b0;
      cmd_mode_array <= 1'b0;
    end else if (cmd_hit && !cmd_bad) begin
      cmd_pend <= 1'b1;
      cmd_write <= pwdata[CMD_WRITE];
      cmd_pair <= pwdata[CMD_PAIR]; // Two command writes in one go
      cmd_mode_array <= pwdata[CMD_MODE_ARRAY] && pwdata[CMD_WRITE];
    end else if (cmd_pend && req.ready) begin
      cmd_pend <= 1'b0;
    end
  end

  // Sticky refusal flag; a new refusal beats the clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      refused <= 1'b0;
    end else if (cmd_hit && cmd_bad) begin
      refused <= 1'b1;
    end else if (wr_acc && paddr == OFS_STATUS && pwdata[ST_REFUSED]) begin
      refused <= 1'b0;
    end
  end

  assign req.valid = cmd_pend;
  assign req.is_write = cmd_write;
  assign req.pair = cmd_pair;
  assign req.addr = addr_reg;
  assign req.wdata = wdata_reg;
  assign req.wdata2 = wdata2_reg;

  // Reset/sleep pin: low from system reset, held the minimum pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reset_sleep_n <= 1'b0;
    end else if (!reset_sleep_n) begin
      // Release only after the minimum pulse and when software allows
      if (rst_cnt >= CNT_W'(RESET_PULSE_CYC) && !ctrl[CTRL_SLEEP]) begin
        reset_sleep_n <= 1'b1;
      end
    end else if (ctrl[CTRL_SLEEP] && !cyc_busy) begin
      // Also the way to abort a running erase or program
      reset_sleep_n <= 1'b0;
    end
  end

  // Reset pulse and wake-up counters, both saturating
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rst_cnt <= '0;
      wake_cnt <= '0;
    end else if (!reset_sleep_n) begin
      wake_cnt <= '0;
      if (rst_cnt < CNT_W'(RESET_PULSE_CYC)) begin
        rst_cnt <= rst_cnt + CNT_W'(1);
      end
    end else begin
      rst_cnt <= '0;
      if (wake_cnt < CNT_W'(WAKE_MAX_CYC)) begin
        wake_cnt <= wake_cnt + CNT_W'(1);
      end
    end
  end

  // Completion indicator synchroniser; low means engine busy
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // Pin idles high through its pull-up; no false busy after reset
      ci_meta <= 1'b1;
      ci_sync <= 1'b1;
    end else begin
      ci_meta <= completion_indicator;
      ci_sync <= ci_meta;
    end
  end

  // Read-mode tracking: array mode after wake or read-array write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      array_mode <= 1'b0;
    end else if (!reset_sleep_n) begin
      array_mode <= 1'b1; // Device comes back in array mode
    end else if (req.done && cmd_mode_array) begin
      array_mode <= 1'b1;
    end else if (req.done && cmd_write) begin
      array_mode <= 1'b0; // Other commands leave array mode
    end else if (!ci_sync && write_ok) begin
      // Busy engine: software must write read-array afterwards
      array_mode <= 1'b0;
    end
  end

  // Status word
  always_comb begin
    status = '0;
    status[ST_CYC_BUSY] = cyc_busy;
    status[ST_WRITE_OK] = write_ok;
    status[ST_READ_OK] = read_ok;
    status[ST_ENGINE_READY] = ci_sync;
    status[ST_ARRAY_MODE] = array_mode;
    status[ST_REFUSED] = refused;
    status[ST_SLEEPING] = !reset_sleep_n;
  end

  // Read mux; unmapped addresses return zero with an error
  always_comb begin
    prdata = '0;
    case (paddr)
      OFS_CTRL: prdata = {30'h0, ctrl};
      OFS_ADDR: prdata[ADDR_W-1:0] = addr_reg;
      OFS_WDATA: prdata[DATA_W-1:0] = wdata_reg;
      OFS_WDATA2: prdata[DATA_W-1:0] = wdata2_reg;
      OFS_RDATA: prdata[DATA_W-1:0] = req.rdata;
      OFS_STATUS: prdata = status;
      default: prdata = '0;
    endcase
  end

  fmc_cycle #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) u_cycle (
    .pclk(pclk),
    .presetn(presetn),
    .req(req),
    .select_a(select_a),
    .select_b(select_b),
    .select_c(select_c),
    .output_drive_n(output_drive_n),
    .write_strobe_n(write_strobe_n),
    .flash_addr(flash_addr),
    .data_lines_out(data_lines_out),
    .data_lines_oe(data_lines_oe),
    .data_lines_in(data_lines_in)
  );
endmodule : fmc_top

/* File: bench/fmc_flash_model.sv */
`timescale 1ns/1ps
// Behavioural flash device on the far side of the pins
module fmc_flash_model
  import fmc_pkg::*;
#(
  parameter int ADDR_W = 24,
  parameter logic [15:0] CMD_ARRAY = 16'h00FF, // Command codes are arbitrary
  parameter logic [15:0] CMD_PROG = 16'h0040,
  parameter int BUSY_CYC = 200 // Engine run time in clocks
) (
  input wire logic pclk,
  input wire logic select_a,
  input wire logic select_b,
  input wire logic select_c,
  input wire logic output_drive_n,
  input wire logic write_strobe_n,
  input wire logic reset_sleep_n,
  input wire logic program_enable_level,
  input wire logic [ADDR_W-1:0] flash_addr,
  input wire logic [15:0] data_lines_out,
  input wire logic data_lines_oe,
  output logic [15:0] data_lines_in,
  output logic completion_indicator
);
  logic [15:0] mem [16]; // Small array on the low address bits
  logic stat_mode = 1'b0; // Reads return status
  logic armed = 1'b0; // First write of a program pair seen
  logic go = 1'b0; // Toggles to start the engine
  logic go_seen = 1'b0; // Last start taken by the engine
  logic busy = 1'b0; // Engine running
  logic aborted = 1'b0; // Engine stopped by reset/sleep
  logic flip = 1'b0; // Floating lines change every cycle, never a stale value
  logic [3:0] p_idx; // Latched program address
  logic [15:0] p_val; // Latched program data
  int cnt = 0; // Engine cycles left
  // Select decode; all three high falls out as deselected
  wire enabled = select_c ? !(select_a && select_b) : (!select_a && !select_b);
  // Drive only when selected, awake, output on and strobe idle
  wire drive = enabled && reset_sleep_n && !output_drive_n && write_strobe_n;
  wire [15:0] flt = flip ? 16'h5A5A : 16'hA5A5;
  // Status: ready bit, low bits float while busy, high byte unused
  wire [15:0] st = {flt[15:8], !busy, busy ? flt[6:0] : 7'h00};
  wire [15:0] rd = stat_mode ? st : mem[flash_addr[3:0]];
  assign data_lines_in = data_lines_oe ? data_lines_out : (drive ? rd : flt);
  // Open drain with pull-up: low while running or after an abort
  assign completion_indicator = !(busy || aborted);
  // Command entry: latch on strobe rise; reset returns to array reads
  always @(posedge write_strobe_n or negedge reset_sleep_n) begin
    if (!reset_sleep_n) begin
      stat_mode = 1'b0;
      armed = 1'b0;
    end else if (enabled) begin
      if (armed) begin
        armed = 1'b0;
        stat_mode = 1'b1;
        // Second write starts the engine only with program enable high
        if (program_enable_level && !busy) begin
          p_idx = flash_addr[3:0];
          p_val = data_lines_in;
          go = !go;
        end
      end else if (data_lines_in == CMD_PROG) begin
        armed = 1'b1;
      end else begin
        stat_mode = (data_lines_in != CMD_ARRAY);
      end
    end
  end
  // Engine: runs on its own regardless of selects; reset/sleep aborts it
  always @(posedge pclk) begin
    flip <= !flip;
    if (!reset_sleep_n) begin
      aborted <= aborted || busy;
      busy <= 1'b0;
      go_seen <= go;
    end else begin
      aborted <= 1'b0;
      if (go != go_seen) begin
        go_seen <= go;
        busy <= 1'b1;
        cnt <= BUSY_CYC;
      end else if (busy) begin
        cnt <= cnt - 1;
        if (cnt == 1) begin
          busy <= 1'b0;
          mem[p_idx] <= p_val;
        end
      end
    end
  end
endmodule : fmc_flash_model

/* File: bench/fmc_top_props.sv */
`timescale 1ns/1ps
// Pin and bus relations watched at the controller's ports
module fmc_top_props
  import fmc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic select_a,
  input wire logic select_b,
  input wire logic select_c,
  input wire logic output_drive_n,
  input wire logic write_strobe_n,
  input wire logic reset_sleep_n,
  input wire logic data_lines_oe
);
  logic [CNT_W-1:0] low_cnt; // Cycles reset_sleep_n has been low, saturating
  logic [CNT_W-1:0] wake_cnt; // Cycles since reset_sleep_n rose, saturating
  wire sel_on = !select_a && !select_b && !select_c; // Device enabled
  // Pulse and wake counters
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      low_cnt <= '0;
      wake_cnt <= '0;
    end else if (!reset_sleep_n) begin
      low_cnt <= low_cnt + CNT_W'(!(&low_cnt));
      wake_cnt <= '0;
    end else begin
      low_cnt <= '0;
      wake_cnt <= wake_cnt + CNT_W'(!(&wake_cnt));
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_strobe_low;
    !write_strobe_n [*7];
  endsequence
  sequence s_strobe_release;
    write_strobe_n && sel_on && data_lines_oe;
  endsequence
  a_strobe_width: assert property ($fell(write_strobe_n) |-> s_strobe_low ##1 s_strobe_release)
    else $error("write strobe width or release wrong");
  a_strobe_selected: assert property (!write_strobe_n |-> sel_on && data_lines_oe && output_drive_n)
    else $error("write strobe without select or data");
  a_read_selected: assert property (!output_drive_n |-> sel_on && !data_lines_oe && write_strobe_n)
    else $error("read cycle conditions broken");
  a_sleep_quiet: assert property (!reset_sleep_n |-> write_strobe_n && output_drive_n)
    else $error("pin cycle while asleep");
  a_reset_pulse: assert property ($rose(reset_sleep_n) |-> low_cnt >= RESET_PULSE_CYC - 1)
    else $error("reset pulse too short");
  a_wake_write: assert property ($fell(write_strobe_n) |-> wake_cnt >= WAKE_WRITE_CYC - 1)
    else $error("write too soon after wake");
  a_wake_read: assert property ($fell(output_drive_n) |-> wake_cnt >= WAKE_READ_CYC - 1)
    else $error("read too soon after wake");
  a_sleep_request: assert property (psel && penable && pwrite && paddr == OFS_CTRL &&
    pwdata[CTRL_SLEEP] |-> ##[1:60] !reset_sleep_n)
    else $error("sleep request not applied");
  a_apb_unmapped: assert property (psel && penable && paddr > OFS_STATUS |-> pready && pslverr)
    else $error("unmapped access not flagged");
endmodule : fmc_top_props
bind fmc_top fmc_top_props u_fmc_top_props (.*);

/* File: bench/fmc_top_test.sv */
`timescale 1ns/1ps
// Self-checking bench: APB orders in, behavioural flash behind the pins
module fmc_top_test
  import fmc_pkg::*;
;
  localparam logic [15:0] C_PROG = 16'h0040; // Program setup code for the model
  localparam logic [15:0] C_ARRAY = 16'h00FF; // Read-array code for the model
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic select_a, select_b, select_c, output_drive_n, write_strobe_n, reset_sleep_n;
  logic program_enable_level, data_lines_oe, completion_indicator;
  logic [23:0] flash_addr;
  logic [15:0] data_lines_out, data_lines_in;
  int n_fail, compares, cyc;
  fmc_top u_fmc_top (.*);
  fmc_flash_model #(.CMD_ARRAY(C_ARRAY), .CMD_PROG(C_PROG)) u_fmc_flash_model (.*);
  // 100 MHz clock
  initial begin
    pclk = 1'b0;
    forever #5 pclk = !pclk;
  end
  // Hang guard: two wake-ups plus polling stay far below this
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 40000) begin
      n_fail++;
      summarize();
    end
  end
  task automatic summarize();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : summarize
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk
  function automatic logic [31:0] flg(input logic v);
    return {31'h0, v};
  endfunction : flg
  // One APB transfer; waits an edge first so strobes never change twice in a step
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    logic rdy;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Answer is settled mid-cycle and is what the closing edge samples
    do begin
      @(negedge pclk);
      rdy = pready;
      q = prdata;
      e = pslverr;
      @(posedge pclk);
    end while (rdy !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic apb_w(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask : apb_w
  task automatic rd_st(output logic [31:0] q);
    logic e;
    apb(1'b0, OFS_STATUS, 32'h0, q, e);
  endtask : rd_st
  // Poll one status bit until it reaches the wanted level, bounded
  task automatic wait_st(input int b, input logic v);
    logic [31:0] q;
    int n;
    n = 0;
    rd_st(q);
    while (q[b] !== v && n < 4000) begin
      rd_st(q);
      n++;
    end
    chk(flg(q[b]), flg(v), "status wait");
  endtask : wait_st
  // Load address and data, start a flash cycle, wait, fetch read data
  task automatic op(input logic [23:0] a, input logic [15:0] w1, input logic [15:0] w2,
                    input logic [31:0] cmd, output logic [31:0] rd);
    logic e;
    apb_w(OFS_ADDR, {8'h00, a});
    apb_w(OFS_WDATA, {16'h0000, w1});
    apb_w(OFS_WDATA2, {16'h0000, w2});
    apb_w(OFS_CMD, cmd);
    wait_st(ST_CYC_BUSY, 1'b0);
    apb(1'b0, OFS_RDATA, 32'h0, rd, e);
  endtask : op
  // Reset values, unmapped address, power-on wake-up
  task automatic t_regs();
    logic [31:0] q;
    logic e;
    apb(1'b0, OFS_CTRL, 32'h0, q, e);
    chk(q, 32'h0, "ctrl reset");
    rd_st(q);
    chk(flg(q[ST_SLEEPING]), 32'h1, "asleep at reset");
    apb(1'b0, 12'h020, 32'h0, q, e);
    chk(q, 32'h0, "unmapped data");
    chk(flg(e), 32'h1, "unmapped error");
    wait_st(ST_WRITE_OK, 1'b1);
    rd_st(q);
    chk(flg(q[ST_ARRAY_MODE]), 32'h1, "array mode");
  endtask : t_regs
  // Program pair, busy status, read-array, read back
  task automatic t_program();
    logic [31:0] q;
    apb_w(OFS_CTRL, 32'h1);
    op(24'h000001, C_PROG, 16'hC3A5, 32'hB, q);
    op(24'h000001, 16'h0, 16'h0, 32'h1, q);
    chk(flg(q[7]), 32'h0, "busy status");
    rd_st(q);
    chk(flg(q[ST_ENGINE_READY]), 32'h0, "engine busy");
    chk(flg(q[ST_ARRAY_MODE]), 32'h0, "array mode left");
    wait_st(ST_ENGINE_READY, 1'b1);
    op(24'h000001, 16'h0, 16'h0, 32'h1, q);
    chk({24'h0, q[7:0]}, 32'h80, "ready status");
    op(24'h000001, C_ARRAY, 16'h0, 32'h7, q);
    rd_st(q);
    chk(flg(q[ST_ARRAY_MODE]), 32'h1, "array mode back");
    op(24'h000001, 16'h0, 16'h0, 32'h1, q);
    chk(q, 32'h0000C3A5, "programmed word");
  endtask : t_program
  // Program attempt with program enable low must leave the word alone
  task automatic t_lockout();
    logic [31:0] q;
    apb_w(OFS_CTRL, 32'h0);
    op(24'h000001, C_PROG, 16'h0F0F, 32'hB, q);
    rd_st(q);
    chk(flg(q[ST_ENGINE_READY]), 32'h1, "no engine run");
    op(24'h000001, C_ARRAY, 16'h0, 32'h7, q);
    op(24'h000001, 16'h0, 16'h0, 32'h1, q);
    chk(q, 32'h0000C3A5, "word kept");
  endtask : t_lockout
  // Sleep aborts a running program; commands refused until awake again
  task automatic t_abort();
    logic [31:0] q;
    apb_w(OFS_CTRL, 32'h1);
    op(24'h000002, C_PROG, 16'h1234, 32'hB, q);
    apb_w(OFS_CTRL, 32'h3);
    wait_st(ST_SLEEPING, 1'b1);
    rd_st(q);
    chk(flg(q[ST_ENGINE_READY]), 32'h0, "abort indicator");
    apb_w(OFS_CMD, 32'h3);
    rd_st(q);
    chk(flg(q[ST_REFUSED]), 32'h1, "asleep refuses");
    apb_w(OFS_STATUS, 32'h20);
    rd_st(q);
    chk(flg(q[ST_REFUSED]), 32'h0, "refused cleared");
    apb_w(OFS_CTRL, 32'h1);
    wait_st(ST_SLEEPING, 1'b0);
    wait_st(ST_WRITE_OK, 1'b1);
    rd_st(q);
    chk(flg(q[ST_ENGINE_READY]), 32'h1, "abort over");
    op(24'h000001, 16'h0, 16'h0, 32'h1, q);
    chk(q, 32'h0000C3A5, "array after wake");
  endtask : t_abort
  // Main sequence
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    n_fail = 0;
    compares = 0;
    cyc = 0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_program();
    t_lockout();
    t_abort();
    summarize();
  end
endmodule : fmc_top_test
